// *** inc/sffe_pkg.sv ***
// package for the serial flash interface front end
package sffe_pkg;
  localparam int CLK_MHZ = 50;
  // powerup_write_delay in microseconds; figure chosen, not documented
  localparam int PUW_US = 100;
  localparam int PUW_CYC = PUW_US * CLK_MHZ;
  localparam int QE_BIT = 9;
  localparam logic [1:0] LOCK_SW = 2'h0;
  localparam logic [1:0] LOCK_HW = 2'h1;
  localparam logic [7:0] OP_WREN = 8'h06;
  localparam logic [7:0] OP_WRDI = 8'h04;
  localparam logic [7:0] OP_WRSR = 8'h01;
  localparam logic [7:0] OP_PROG = 8'h02;
  localparam logic [7:0] OP_SE = 8'h20;
  localparam logic [7:0] OP_BE32 = 8'h52;
  localparam logic [7:0] OP_BE64 = 8'hD8;
  localparam logic [7:0] OP_CE = 8'hC7;
  localparam logic [7:0] OP_CE2 = 8'h60;
  localparam logic [7:0] OP_PD = 8'hB9;
  localparam logic [7:0] OP_RPD = 8'hAB;
  localparam logic [7:0] OP_DOR = 8'h3B;
  localparam logic [7:0] OP_DIOR = 8'hBB;
  localparam logic [7:0] OP_QOR = 8'h6B;
  localparam logic [7:0] OP_QIOR = 8'hEB;
  localparam logic [7:0] OP_WQR = 8'hE7;
  localparam logic [7:0] OP_OQR = 8'hE3;
  typedef enum logic [1:0] {LN1, LN2, LN4} sffe_lanes_t;
  typedef struct packed {
    logic [7:0] opcode;
    logic       valid;
  } sffe_cmd_t;
  typedef struct packed {
    logic       statusLockModeHi;
    logic       statusLockModeLo;
    logic       quadLaneEnable;
    logic       protectGranuleSelect;
    logic       protectFromBottom;
    logic [2:0] protectSpan;
  } sffe_status_t;
endpackage

// *** hdl/sffe_top.sv ***
// serial flash interface front end and write-protect gating
// Operation
// - single lane: serial input sampled on rising serial clock edges
// - single lane: serial output changes on falling serial clock edges
// - dual/quad lanes sampled on rising, driven on falling clock edges
// - quad needs quad lane enable; protect and pause pins become lanes 2, 3
// - only clock modes 0 and 3; clock level stable at select edges
// - dual reads turn serial in and out into lanes 0 and 1
// - quad reads use all four lanes
// - active-low protect pin gates status writes with lock bits
// - protect pin function off while quad lane enable set
// - pause starts at pause fall if clock low, else next falling clock
// - pause ends at pause rise if clock low, else next falling clock
// - while paused: output off, inputs ignored, state kept
// - pause only in single and dual lane operation
// - during supply reset nothing operates
// - write-class instructions rejected until power-up write delay elapses
// - write enable latch zero at power-up, required for writes
// - write enable latch cleared when write operation finishes
// - lock and protect bits make the array portion read-only; protect bits unused here, array writes not gated
// - in power-down only release is recognised
// - status write allowed by lock bits, latch and protect pin
// - first instruction only after select falls from high
// - deselected: all output lanes high impedance
// - quad lane enable is status bit 9; zero enables pin functions
// - hardware lock mode with protect pin low blocks status writes
`timescale 1ns/1ps
`default_nettype none
module sffe_top #(
  parameter int PUW_CYCLES = sffe_pkg::PUW_CYC
) (
  input  wire logic                 clock,
  input  wire logic                 sys_rst,
  input  wire logic                 chipSelN,
  input  wire logic                 serialClk,
  input  wire logic [3:0]           laneIn,
  output logic [3:0]                laneOut,
  output logic [3:0]                laneOe,
  input  wire sffe_pkg::sffe_status_t statusIn,
  input  wire logic [7:0]           readData,
  output logic                      readTake,
  output sffe_pkg::sffe_cmd_t       cmdOut,
  output logic [7:0]                rxByte,
  output logic                      rxValid,
  input  wire logic                 opDone,
  output logic                      writeEnableLatch,
  output logic                      statusWriteOk,
  output logic                      writeLockout,
  output logic                      powerDown,
  output logic                      paused
);
  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  logic [6:0] s1_ff, s2_ff, s3_ff;
  always_ff @(posedge clock or posedge sys_rst)
    if (sys_rst)
    begin
      s1_ff <= 7'h7f;
      s2_ff <= 7'h7f;
      s3_ff <= 7'h7f;
    end
    else
    begin
      s1_ff <= {chipSelN, serialClk, laneIn, 1'b1};
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  logic csN, sck, sckPrev, csPrev;
  logic [3:0] din;
  assign csN = s2_ff[6];
  assign sck = s2_ff[5];
  assign din = s2_ff[4:1];
  assign csPrev = s3_ff[6];
  assign sckPrev = s3_ff[5];
  logic sckRise, sckFall, csRise;
  assign sckRise = sck & ~sckPrev & ~csN;
  assign sckFall = ~sck & sckPrev & ~csN;
  assign csRise = csN & ~csPrev;

  logic quadEn;
  assign quadEn = statusIn.quadLaneEnable;

  // ----------------------------------------
  // pause
  // ----------------------------------------
  logic pauseN, pauseReq, pause_ff, lanes2Ok;
  sffe_pkg::sffe_lanes_t mode_ff;
  assign pauseN = din[3];
  assign pauseReq = ~quadEn & ~csN & ~pauseN & (mode_ff != sffe_pkg::LN4);
  always_ff @(posedge clock or posedge sys_rst)
    if (sys_rst)
      pause_ff <= 1'b0;
    else if (csN)
      pause_ff <= 1'b0;
    else if (pauseReq != pause_ff && (~sck || sckFall))
      pause_ff <= pauseReq;
  logic active;
  assign active = ~pause_ff;

  // ----------------------------------------
  // shifter
  // ----------------------------------------
  logic armed_ff, pwrDn_ff, wel_ff, opValid_ff, byteDone;
  logic [7:0] sh_ff, op_ff, tx_ff;
  logic [3:0] cnt_ff;
  logic [2:0] step;
  always_comb
    case (mode_ff)
      sffe_pkg::LN2: step = 3'd2;
      sffe_pkg::LN4: step = 3'd4;
      default:       step = 3'd1;
    endcase
  assign byteDone = (cnt_ff + {1'b0, step}) >= 4'd8;

  always_ff @(posedge clock or posedge sys_rst)
    if (sys_rst)
      armed_ff <= 1'b0;
    else if (csN)
      armed_ff <= 1'b1;
    else if (csRise)
      armed_ff <= 1'b1;

  always_ff @(posedge clock or posedge sys_rst)
    if (sys_rst)
    begin
      sh_ff <= 8'h00;
      cnt_ff <= 4'h0;
      opValid_ff <= 1'b0;
      op_ff <= 8'h00;
    end
    else if (csN)
    begin
      cnt_ff <= 4'h0;
      opValid_ff <= 1'b0;
    end
    else if (armed_ff && active && sckRise)
    begin
      case (mode_ff)
        sffe_pkg::LN2: sh_ff <= {sh_ff[5:0], din[1:0]};
        sffe_pkg::LN4: sh_ff <= {sh_ff[3:0], din};
        default:       sh_ff <= {sh_ff[6:0], din[0]};
        endcase
      cnt_ff <= byteDone ? 4'h0 : cnt_ff + {1'b0, step};
      if (byteDone && !opValid_ff)
      begin
        opValid_ff <= 1'b1;
        op_ff <= {sh_ff[6:0], din[0]};
      end
    end

  logic [7:0] rxNow;
  assign rxNow = (mode_ff == sffe_pkg::LN4) ? {sh_ff[3:0], din} :
                 (mode_ff == sffe_pkg::LN2) ? {sh_ff[5:0], din[1:0]} : {sh_ff[6:0], din[0]};
  logic opEdge;
  assign opEdge = armed_ff & active & sckRise & byteDone & ~opValid_ff;

  // ----------------------------------------
  // power-up lockout
  // ----------------------------------------
  logic [$clog2(PUW_CYCLES+1)-1:0] puw_ff;
  always_ff @(posedge clock or posedge sys_rst)
    if (sys_rst)
      puw_ff <= '0;
    else if (puw_ff != PUW_CYCLES[$clog2(PUW_CYCLES+1)-1:0])
      puw_ff <= puw_ff + 1'b1;
  logic lock;
  assign lock = puw_ff != PUW_CYCLES[$clog2(PUW_CYCLES+1)-1:0];

  function automatic logic isWrite(input logic [7:0] o);
    isWrite = o == sffe_pkg::OP_WREN || o == sffe_pkg::OP_WRSR || o == sffe_pkg::OP_PROG ||
              o == sffe_pkg::OP_SE || o == sffe_pkg::OP_BE32 || o == sffe_pkg::OP_BE64 ||
              o == sffe_pkg::OP_CE || o == sffe_pkg::OP_CE2;
  endfunction

  logic srOk;
  always_comb
  begin
    srOk = wel_ff;
    if (statusIn.statusLockModeHi)
      srOk = 1'b0;
    else if (statusIn.statusLockModeLo && !quadEn && !din[2])
      srOk = 1'b0;
  end

  logic accept;
  always_comb
  begin
    accept = 1'b1;
    if (pwrDn_ff && rxNow != sffe_pkg::OP_RPD)
      accept = 1'b0;
    else if (lock && isWrite(rxNow))
      accept = 1'b0;
    else if (isWrite(rxNow) && rxNow != sffe_pkg::OP_WREN && !wel_ff)
      accept = 1'b0;
    else if (rxNow == sffe_pkg::OP_WRSR && !srOk)
      accept = 1'b0;
    else if ((rxNow == sffe_pkg::OP_QOR || rxNow == sffe_pkg::OP_QIOR ||
              rxNow == sffe_pkg::OP_WQR || rxNow == sffe_pkg::OP_OQR) && !quadEn)
      accept = 1'b0;
  end

  always_ff @(posedge clock or posedge sys_rst)
    if (sys_rst)
      cmdOut <= '0;
    else
    begin
      cmdOut.valid <= opEdge & accept;
      if (opEdge)
        cmdOut.opcode <= rxNow;
    end

  always_ff @(posedge clock or posedge sys_rst)
    if (sys_rst)
    begin
      rxByte <= 8'h00;
      rxValid <= 1'b0;
    end
    else
    begin
      rxValid <= armed_ff & active & sckRise & byteDone & opValid_ff;
      rxByte <= rxNow;
    end

  // ----------------------------------------
  // latch and power-down
  // ----------------------------------------
  always_ff @(posedge clock or posedge sys_rst)
    if (sys_rst)
      wel_ff <= 1'b0;
    else if (opEdge && accept && rxNow == sffe_pkg::OP_WREN)
      wel_ff <= 1'b1;
    else if (opDone)
      wel_ff <= 1'b0;
    else if (opEdge && accept && rxNow == sffe_pkg::OP_WRDI)
      wel_ff <= 1'b0;

  always_ff @(posedge clock or posedge sys_rst)
    if (sys_rst)
      pwrDn_ff <= 1'b0;
    else if (opEdge && accept && rxNow == sffe_pkg::OP_PD)
      pwrDn_ff <= 1'b1;
    else if (opEdge && rxNow == sffe_pkg::OP_RPD)
      pwrDn_ff <= 1'b0;

  // ----------------------------------------
  // lane mode
  // ----------------------------------------
  always_ff @(posedge clock or posedge sys_rst)
    if (sys_rst)
      mode_ff <= sffe_pkg::LN1;
    else if (csN)
      mode_ff <= sffe_pkg::LN1;
    else if (opEdge && accept && (rxNow == sffe_pkg::OP_DIOR))
      mode_ff <= sffe_pkg::LN2;
    else if (opEdge && accept && (rxNow == sffe_pkg::OP_QIOR || rxNow == sffe_pkg::OP_WQR ||
                                  rxNow == sffe_pkg::OP_OQR))
      mode_ff <= sffe_pkg::LN4;

  // ----------------------------------------
  // output lanes
  // ----------------------------------------
  logic outMode;
  logic [3:0] txCnt_ff;
  always_ff @(posedge clock or posedge sys_rst)
    if (sys_rst)
      outMode <= 1'b0;
    else if (csN)
      outMode <= 1'b0;
    else if (opEdge && accept)
      outMode <= rxNow == sffe_pkg::OP_DOR || rxNow == sffe_pkg::OP_QOR;

  logic [2:0] txStep;
  assign txStep = (outMode && op_ff == sffe_pkg::OP_DOR) ? 3'd2 :
                  (outMode && op_ff == sffe_pkg::OP_QOR) || mode_ff == sffe_pkg::LN4 ? 3'd4 :
                  mode_ff == sffe_pkg::LN2 ? 3'd2 : 3'd1;

  always_ff @(posedge clock or posedge sys_rst)
    if (sys_rst)
    begin
      tx_ff <= 8'h00;
      txCnt_ff <= 4'h0;
      readTake <= 1'b0;
    end
    else
    begin
      readTake <= 1'b0;
      if (csN)
        txCnt_ff <= 4'h0;
      else if (opValid_ff && active && sckFall)
      begin
        if (txCnt_ff == 4'h0)
        begin
          tx_ff <= readData;
          readTake <= 1'b1;
        end
        else
          tx_ff <= tx_ff << txStep;
        txCnt_ff <= (txCnt_ff + {1'b0, txStep}) >= 4'd8 ? 4'h0 : txCnt_ff + {1'b0, txStep};
      end
    end

  always_ff @(posedge clock or posedge sys_rst)
    if (sys_rst)
    begin
      laneOut <= 4'h0;
      laneOe <= 4'h0;
    end
    else if (csN || pause_ff || !opValid_ff)
      laneOe <= 4'h0;
    else
    begin
      case (txStep)
        3'd4:
        begin
          laneOut <= tx_ff[7:4];
          laneOe <= 4'hf;
        end
        3'd2:
        begin
          laneOut <= {2'b00, tx_ff[7:6]};
          laneOe <= 4'h3;
        end
        default:
        begin
          laneOut <= {2'b00, tx_ff[7], 1'b0};
          laneOe <= 4'h2;
        end
      endcase
    end

  always_ff @(posedge clock or posedge sys_rst)
    if (sys_rst)
    begin
      writeEnableLatch <= 1'b0;
      statusWriteOk <= 1'b0;
      writeLockout <= 1'b1;
      powerDown <= 1'b0;
      paused <= 1'b0;
    end
    else
    begin
      writeEnableLatch <= wel_ff;
      statusWriteOk <= srOk;
      writeLockout <= lock;
      powerDown <= pwrDn_ff;
      paused <= pause_ff;
    end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_wel_clear;
    @(posedge clock) disable iff (sys_rst)
      opDone && !(opEdge && accept && rxNow == sffe_pkg::OP_WREN) |=> !wel_ff;
  endproperty
  a_wel_clear: assert property (p_wel_clear) else $error("latch not cleared");
  property p_desel_hiz;
    @(posedge clock) disable iff (sys_rst) csN |=> laneOe == 4'h0;
  endproperty
  a_desel_hiz: assert property (p_desel_hiz) else $error("lanes driven deselected");
  property p_pause_hiz;
    @(posedge clock) disable iff (sys_rst) pause_ff |=> laneOe == 4'h0;
  endproperty
  a_pause_hiz: assert property (p_pause_hiz) else $error("driving while paused");
  property p_lock;
    @(posedge clock) disable iff (sys_rst) lock && opEdge && isWrite(rxNow) |=> !cmdOut.valid;
  endproperty
  a_lock: assert property (p_lock) else $error("write taken in lockout");
  property p_pd;
    @(posedge clock) disable iff (sys_rst)
      pwrDn_ff && opEdge && rxNow != sffe_pkg::OP_RPD |=> !cmdOut.valid;
  endproperty
  a_pd: assert property (p_pd) else $error("instruction in power-down");
  property p_quad_nopause;
    @(posedge clock) disable iff (sys_rst) quadEn |=> !pause_ff;
  endproperty
  a_quad_nopause: assert property (p_quad_nopause) else $error("pause in quad");
  property p_hwlock;
    @(posedge clock) disable iff (sys_rst)
      statusIn.statusLockModeLo && !statusIn.statusLockModeHi && !quadEn && !din[2] |-> !srOk;
  endproperty
  a_hwlock: assert property (p_hwlock) else $error("status write not locked");
  property p_single;
    @(posedge clock) disable iff (sys_rst) csN |=> mode_ff == sffe_pkg::LN1;
  endproperty
  a_single: assert property (p_single) else $error("lanes not single");
endmodule
`default_nettype wire

// *** tb/sffe_spi_master.sv ***
// spi bus master model that drives the front end pins
`timescale 1ns/1ps
`default_nettype none
module sffe_spi_master (
  input  wire logic clock,
  output logic      chipSelN,
  output logic      serialClk,
  output logic      mosi
);
  logic cpol;

  initial
  begin
    chipSelN = 1'b1;
    serialClk = 1'b0;
    mosi = 1'b0;
    cpol = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clock);
  endtask

  // select falls with the clock parked at its idle level
  task automatic frame_start(input logic mode3);
    cpol = mode3;
    serialClk <= mode3;
    wait_clk(4);
    chipSelN <= 1'b0;
    wait_clk(4);
  endtask

  // data set in the low phase, taken on the rise
  task automatic send_bits(input logic [7:0] b, input int n);
    for (int i = 0; i < n; i++)
    begin
      serialClk <= 1'b0;
      mosi <= b[7-i];
      wait_clk(4);
      serialClk <= 1'b1;
      wait_clk(4);
    end
  endtask

  // clock back to idle level, then deselect; released line flips
  task automatic frame_end;
    serialClk <= cpol;
    wait_clk(4);
    chipSelN <= 1'b1;
    mosi <= ~mosi;
    wait_clk(8);
  endtask
endmodule
`default_nettype wire

// *** tb/sffe_top_tb_top.sv ***
// self-checking bench for the serial flash interface front end
`timescale 1ns/1ps
`default_nettype none
module sffe_top_tb_top;
  localparam int PUW = 200;
  logic                   clock, sys_rst, chipSelN, serialClk, mosi;
  logic                   protN, pauseN, opDone, lane1Drv, readTake, rxValid;
  logic                   writeEnableLatch, statusWriteOk, writeLockout, powerDown, paused;
  logic [3:0]             laneIn, laneOut, laneOe;
  logic [7:0]             readData, rxByte, lastOp, lastRx;
  logic [31:0]            seed;
  sffe_pkg::sffe_status_t statusIn;
  sffe_pkg::sffe_cmd_t    cmdOut;
  int                     num_errors, checks_done, nValid, expLatch, expPd, expLock;
  logic [7:0]             rdOps [6];

  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // wire level: the design's drive wins over the master's
  assign laneIn[0] = laneOe[0] ? laneOut[0] : mosi;
  assign laneIn[1] = laneOe[1] ? laneOut[1] : lane1Drv;
  assign laneIn[2] = laneOe[2] ? laneOut[2] : protN;
  assign laneIn[3] = laneOe[3] ? laneOut[3] : pauseN;

  sffe_spi_master i_master (
    .clock     (clock),
    .chipSelN  (chipSelN),
    .serialClk (serialClk),
    .mosi      (mosi)
  );

  sffe_top #(.PUW_CYCLES(PUW)) i_dut (
    .clock            (clock),
    .sys_rst          (sys_rst),
    .chipSelN         (chipSelN),
    .serialClk        (serialClk),
    .laneIn           (laneIn),
    .laneOut          (laneOut),
    .laneOe           (laneOe),
    .statusIn         (statusIn),
    .readData         (readData),
    .readTake         (readTake),
    .cmdOut           (cmdOut),
    .rxByte           (rxByte),
    .rxValid          (rxValid),
    .opDone           (opDone),
    .writeEnableLatch (writeEnableLatch),
    .statusWriteOk    (statusWriteOk),
    .writeLockout     (writeLockout),
    .powerDown        (powerDown),
    .paused           (paused)
  );

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  always @(posedge clock)
  begin
    seed <= xs(seed);
    readData <= seed[7:0];
    lane1Drv <= seed[8];
    if (cmdOut.valid === 1'b1)
    begin
      nValid <= nValid + 1;
      lastOp <= cmdOut.opcode;
    end
    if (rxValid === 1'b1)
      lastRx <= rxByte;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clock);
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test;
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  function automatic int sr_locked();
    logic hw;
    hw = ({statusIn.statusLockModeHi, statusIn.statusLockModeLo} == sffe_pkg::LOCK_HW);
    return int'(statusIn.statusLockModeHi | (hw & ~statusIn.quadLaneEnable & ~protN));
  endfunction

  // reference model: acceptance of one whole opcode frame
  task automatic issue(input logic [7:0] op, input logic mode3);
    int acc, n0, wr, qd;
    n0 = nValid;
    wr = int'(op == sffe_pkg::OP_WREN || op == sffe_pkg::OP_WRSR);
    qd = int'(op == sffe_pkg::OP_QOR || op == sffe_pkg::OP_QIOR
              || op == sffe_pkg::OP_WQR || op == sffe_pkg::OP_OQR);
    acc = 1;
    if (expPd != 0 && op != sffe_pkg::OP_RPD)
      acc = 0;
    if (wr != 0 && expLock != 0)
      acc = 0;
    if (qd != 0 && statusIn.quadLaneEnable == 1'b0)
      acc = 0;
    if (op == sffe_pkg::OP_WRSR && (expLatch == 0 || sr_locked() != 0))
      acc = 0;
    i_master.frame_start(mode3);
    i_master.send_bits(op, 8);
    i_master.frame_end();
    check(8'(nValid - n0), 8'(acc));
    if (acc != 0)
    begin
      check(lastOp, op);
      if (op == sffe_pkg::OP_WREN)
        expLatch = 1;
      if (op == sffe_pkg::OP_WRDI)
        expLatch = 0;
      if (op == sffe_pkg::OP_PD)
        expPd = 1;
      if (op == sffe_pkg::OP_RPD)
        expPd = 0;
    end
    check({7'h0, writeEnableLatch}, 8'(expLatch));
    check({7'h0, powerDown}, 8'(expPd));
    check({4'h0, laneOe}, 8'h00);
  endtask

  initial
  begin
    rdOps = '{sffe_pkg::OP_DOR, sffe_pkg::OP_DIOR, sffe_pkg::OP_QOR,
              sffe_pkg::OP_QIOR, sffe_pkg::OP_WQR, sffe_pkg::OP_OQR};
    seed = 32'h0000_3a18;
    sys_rst = 1'b1;
    protN = 1'b1;
    pauseN = 1'b1;
    opDone = 1'b0;
    lane1Drv = 1'b0;
    readData = 8'h00;
    statusIn = '0;
    {num_errors, checks_done, nValid, expLatch, expPd} = '0;
    lastOp = 8'h00;
    lastRx = 8'h00;
    expLock = 1;
    wait_clk(10);
    sys_rst <= 1'b0;
    wait_clk(4);
    check({7'h0, writeLockout}, 8'h01);
    issue(sffe_pkg::OP_WREN, 1'b0);
    wait_clk(PUW);
    expLock = 0;
    check({7'h0, writeLockout}, 8'h00);
    issue(sffe_pkg::OP_WREN, 1'b0);
    opDone <= 1'b1;
    wait_clk(1);
    opDone <= 1'b0;
    wait_clk(3);
    expLatch = 0;
    check({7'h0, writeEnableLatch}, 8'h00);
    issue(sffe_pkg::OP_WRSR, 1'b0);
    issue(sffe_pkg::OP_WREN, 1'b1);
    check({7'h0, statusWriteOk}, 8'h01);
    statusIn.statusLockModeLo <= 1'b1;
    protN <= 1'b0;
    wait_clk(4);
    check({7'h0, statusWriteOk}, 8'h00);
    issue(sffe_pkg::OP_WRSR, 1'b0);
    statusIn.quadLaneEnable <= 1'b1;
    wait_clk(4);
    check({7'h0, statusWriteOk}, 8'h01);
    for (int q = 1; q >= 0; q--)
    begin
      statusIn.quadLaneEnable <= q[0];
      protN <= 1'b1;
      wait_clk(4);
      foreach (rdOps[i])
        issue(rdOps[i], seed[9]);
    end
    i_master.frame_start(1'b0);
    i_master.send_bits(sffe_pkg::OP_WRDI, 4);
    pauseN <= 1'b0;
    i_master.send_bits(8'hff, 2);
    check({6'h0, paused, laneOe[1]}, 8'h02);
    pauseN <= 1'b1;
    i_master.send_bits({sffe_pkg::OP_WRDI[3:0], 4'h0}, 4);
    i_master.frame_end();
    check(lastOp, sffe_pkg::OP_WRDI);
    check({6'h0, paused, writeEnableLatch}, 8'h00);
    expLatch = 0;
    i_master.frame_start(1'b0);
    i_master.send_bits(sffe_pkg::OP_WREN, 5);
    i_master.frame_end();
    check({7'h0, writeEnableLatch}, 8'h00);
    i_master.frame_start(1'b0);
    i_master.send_bits(sffe_pkg::OP_WRDI, 8);
    i_master.send_bits(8'h5a, 8);
    i_master.frame_end();
    check(lastRx, 8'h5a);
    issue(sffe_pkg::OP_PD, 1'b0);
    issue(sffe_pkg::OP_WREN, 1'b0);
    issue(sffe_pkg::OP_RPD, 1'b0);
    finish_test();
  end

  initial
  begin
    #200us;
    num_errors++;
    finish_test();
  end
endmodule
`default_nettype wire
